// ==== hw/emb_cam_pkg.sv ====
// Package of constants for the embedded memory block in content-addressable mode
package emb_cam_pkg;
  localparam int unsigned ENTRIES      = 32;
  localparam int unsigned WORD_W       = 32;
  localparam int unsigned INDEX_W      = 5;
  localparam int unsigned VEC_W        = 16;
  localparam int unsigned WR_CYC_PLAIN = 2;
  localparam int unsigned WR_CYC_MASK  = 3;
  localparam logic [1:0]  WR_CNT_W0    = 2'h0;
  localparam logic [WORD_W-1:0]  INIT_DATA = 32'h0000_0000;
  localparam logic [WORD_W-1:0]  INIT_MASK = 32'h0000_0000;
  localparam logic [VEC_W-1:0]   VEC_ZERO  = 16'h0000;
  localparam logic [INDEX_W-1:0] IDX_ZERO  = 5'h00;
  localparam logic [WORD_W-1:0]  WORD_ZERO = 32'h0000_0000;
endpackage

// ==== hw/emb_cam.sv ====
// Embedded memory block used as a 32 x 32 content-addressable memory with don't-care bits
`timescale 1ns/1ps
`default_nettype none
module emb_cam
  import emb_cam_pkg::*;
#(
  parameter logic [WORD_W-1:0] PRELOAD_DATA = INIT_DATA,
  parameter logic [WORD_W-1:0] PRELOAD_MASK = INIT_MASK
) (
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst,
  // Clear sources and enables
  input  wire logic               clr_local,
  input  wire logic               clr_global,
  input  wire logic               in_clk_en,
  input  wire logic               out_clk_en,
  input  wire logic               in_clr,
  input  wire logic               out_clr,
  // Mode selects
  input  wire logic               encoded_sel,
  input  wire logic               single_port,
  // Write port
  input  wire logic               write_strobe,
  input  wire logic               write_dc,
  input  wire logic [INDEX_W-1:0] write_index,
  input  wire logic [WORD_W-1:0]  write_data,
  input  wire logic [WORD_W-1:0]  write_mask,
  // Search port
  input  wire logic               read_strobe,
  input  wire logic [WORD_W-1:0]  search_word,
  // Results
  output logic [INDEX_W-1:0]      match_index,
  output logic                    match_found,
  output logic [VEC_W-1:0]        match_vec,
  output logic                    match_half,
  output logic                    result_valid,
  output logic                    write_busy
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [ENTRIES-1:0][WORD_W-1:0] data;
    logic [ENTRIES-1:0][WORD_W-1:0] mask;
    logic                     in_we;
    logic                     in_dc;
    logic [INDEX_W-1:0]       in_idx;
    logic [WORD_W-1:0]        in_data;
    logic [WORD_W-1:0]        in_mask;
    logic                     in_re;
    logic [WORD_W-1:0]        in_key;
    logic [1:0]               wr_cnt;
    logic                     wr_act;
    logic [ENTRIES-1:0]       hits;
    logic                     hi_pend;
    logic                     search_ok;
    logic [INDEX_W-1:0]       o_idx;
    logic                     o_found;
    logic [VEC_W-1:0]         o_vec;
    logic                     o_half;
    logic                     o_valid;
  } emb_cam_state_t;

  emb_cam_state_t st;
  emb_cam_state_t next_st;
  logic           clr_all;

  // Reset, local or global clear zeroes the state and reloads every entry with the preload values
  assign clr_all = rst | clr_local | clr_global;

  // Masked compare of one entry
  function automatic logic entry_hit(input logic [WORD_W-1:0] d,
                                     input logic [WORD_W-1:0] m,
                                     input logic [WORD_W-1:0] k);
    entry_hit = ((d ^ k) & ~m) == WORD_ZERO;
  endfunction

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    logic [ENTRIES-1:0] h;
    logic               any;
    logic [INDEX_W-1:0] idx;
    logic               last;
    h = '0;
    any = 1'b0;
    idx = IDX_ZERO;
    last = 1'b0;
    next_st = st;
    // Input registers sample on their own enable
    if (in_clk_en) begin
      next_st.in_we   = write_strobe;
      next_st.in_dc   = write_dc;
      next_st.in_idx  = write_index;
      next_st.in_data = write_data;
      next_st.in_mask = write_mask;
      next_st.in_re   = read_strobe & ~(single_port & write_strobe);
      next_st.in_key  = search_word;
    end
    // Multi-cycle write sequencer; commits on the last cycle
    last = st.wr_cnt == (st.in_dc ? 2'(WR_CYC_MASK - 1) : 2'(WR_CYC_PLAIN - 1));
    if (st.in_we) begin
      next_st.wr_act = 1'b1;
      if (last) begin
        next_st.data[st.in_idx] = st.in_data;
        next_st.mask[st.in_idx] = st.in_dc ? st.in_mask : WORD_ZERO;
        next_st.wr_cnt = WR_CNT_W0;
        next_st.wr_act = 1'b0;
      end else begin
        next_st.wr_cnt = st.wr_cnt + 2'h1;
      end
    end else begin
      next_st.wr_cnt = WR_CNT_W0;
      next_st.wr_act = 1'b0;
    end
    // Compare the key against all entries
    for (int i = 0; i < ENTRIES; i++) begin
      h[i] = entry_hit(st.data[i], st.mask[i], st.in_key);
    end
    for (int i = ENTRIES - 1; i >= 0; i--) begin
      if (h[i]) begin
        idx = INDEX_W'(i);
        any = 1'b1;
      end
    end
    // Output registers on their own enable
    if (out_clk_en) begin
      next_st.o_valid = 1'b0;
      next_st.o_half  = 1'b0;
      if (st.hi_pend) begin
        next_st.o_vec   = st.hits[ENTRIES-1:VEC_W];
        next_st.o_half  = 1'b1;
        next_st.o_valid = st.search_ok;
        next_st.hi_pend = 1'b0;
      end else if (st.in_re) begin
        next_st.search_ok = ~(st.in_we | st.wr_act);
        next_st.o_valid   = ~(st.in_we | st.wr_act);
        next_st.o_idx     = idx;
        next_st.o_found   = any;
        next_st.hits      = h;
        next_st.o_vec     = h[VEC_W-1:0];
        next_st.hi_pend   = ~encoded_sel;
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (clr_all) begin
      st <= '0;
      for (int i = 0; i < ENTRIES; i++) begin
        st.data[i] <= PRELOAD_DATA;
        st.mask[i] <= PRELOAD_MASK;
      end
    end else begin
      st <= next_st;
      if (in_clr) begin
        st.in_we  <= 1'b0;
        st.in_re  <= 1'b0;
        st.wr_cnt <= WR_CNT_W0;
        st.wr_act <= 1'b0;
      end
      if (out_clr) begin
        st.o_idx   <= IDX_ZERO;
        st.o_found <= 1'b0;
        st.o_vec   <= VEC_ZERO;
        st.o_half  <= 1'b0;
        st.o_valid <= 1'b0;
        st.hi_pend <= 1'b0;
      end
    end
  end

  // Outputs straight from state flops
  assign match_index  = st.o_idx;
  assign match_found  = st.o_found;
  assign match_vec    = st.o_vec;
  assign match_half   = st.o_half;
  assign result_valid = st.o_valid;
  assign write_busy   = st.wr_act;

endmodule // emb_cam
`default_nettype wire

// ==== verification/emb_cam_checker.sv ====
// Port assertions for the CAM block
`timescale 1ns/1ps
`default_nettype none
module emb_cam_checker
  import emb_cam_pkg::*;
(
  // Watched ports
  input wire logic clk_sys, rst, clr_local, clr_global, in_clr, out_clr,
  input wire logic in_clk_en, out_clk_en, encoded_sel, write_strobe, write_dc,
  input wire logic read_strobe, match_half, result_valid, write_busy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst || clr_local || clr_global || in_clr || out_clr);
  // Write steps as seen at the ports
  sequence s_wr_go;
    $rose(write_busy);
  endsequence
  sequence s_mask_wr;
    s_wr_go ##0 write_dc ##1 write_busy;
  endsequence
  chk_plain_done: assert property (
    s_wr_go ##0 !write_dc |=> !write_busy) else $error("plain write overran");
  chk_mask_done: assert property (
    s_mask_wr |=> !write_busy) else $error("masked write length wrong");
  chk_search_answer: assert property (
    read_strobe && in_clk_en && out_clk_en && !write_strobe && !$past(write_strobe)
    && !write_busy && !result_valid
    |-> ##2 result_valid && !match_half) else $error("search gave no result");
  chk_second_beat: assert property (
    result_valid && !match_half && !encoded_sel |=> result_valid && match_half)
    else $error("upper half missing");
  chk_beat_pairing: assert property (
    result_valid && match_half |-> $past(result_valid) && !$past(match_half))
    else $error("upper half without lower");
  chk_refuse_busy: assert property (
    result_valid && !match_half |-> !$past(write_busy)) else $error("result during write");
  chk_gate_input: assert property (
    !in_clk_en && $past(!in_clk_en) |=> !result_valid) else $error("gated search answered");
  chk_clear_outs: assert property (disable iff (rst)
    clr_local || clr_global |=> !result_valid && !write_busy) else $error("clear ignored");
endmodule // emb_cam_checker
bind emb_cam emb_cam_checker chk_u (.*);
`default_nettype wire

// ==== verification/emb_cam_collector.sv ====
// User-logic model that assembles the two-beat match map
`timescale 1ns/1ps
`default_nettype none
module emb_cam_collector
  import emb_cam_pkg::*;
(
  // Result side of the block
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic [VEC_W-1:0] match_vec,
  input  wire logic             match_half,
  input  wire logic             result_valid,
  // Assembled map, usable only once both beats are in
  output logic [ENTRIES-1:0]    hits,
  output logic                  hits_ok
);
  // Collect lower then upper half before acting
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hits    <= '0;
      hits_ok <= 1'b0;
    end else begin
      hits_ok <= result_valid & match_half;
      if (result_valid & ~match_half) hits[VEC_W-1:0] <= match_vec;
      if (result_valid & match_half) hits[ENTRIES-1:VEC_W] <= match_vec;
    end
  end
endmodule // emb_cam_collector
`default_nettype wire

// ==== verification/emb_cam_tb.sv ====
// Self-checking bench for the CAM block
`timescale 1ns/1ps
`default_nettype none
module emb_cam_tb;
  import emb_cam_pkg::*;
  logic clk_sys = 0, rst = 1, clr_local = 0, in_clk_en = 1, encoded_sel = 0, single_port = 0;
  logic write_strobe = 0, write_dc = 0, read_strobe = 0, got_v, got_f;
  logic [INDEX_W-1:0] write_index = '0, match_index, got_i;
  logic [WORD_W-1:0]  write_data = '0, write_mask = '0, search_word = '0;
  logic match_found, match_half, result_valid, write_busy, hits_ok;
  logic [VEC_W-1:0]   match_vec;
  logic [ENTRIES-1:0] hits;
  int num_errors = 0, n_compared = 0, cycles = 0;
  emb_cam dut_u (.clr_global(1'b0), .in_clr(1'b0), .out_clr(1'b0), .out_clk_en(1'b1),
                 .*);
  emb_cam_collector coll_u (.*);
  // Clock and hang limit
  initial forever #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (++cycles == 3000) begin num_errors++; stop_test; end
  task automatic stop_test;
    $display("Compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  // Write held for two edges, three with a mask
  task automatic wr(input logic [4:0] i, input logic [31:0] d, m, input logic dc);
    @(posedge clk_sys); #1;
    {write_strobe, write_index, write_data, write_mask, write_dc} = {1'b1, i, d, m, dc};
    repeat (dc ? 3 : 2) @(posedge clk_sys);
    #1 write_strobe = 0;
    chk(write_busy, 1);
    @(posedge clk_sys); #1 chk(write_busy, 0);
  endtask
  // One search; keeps the lower beat, waits for the collector
  task automatic srch(input logic [31:0] w, input logic enc);
    @(posedge clk_sys); #1;
    {search_word, encoded_sel, read_strobe} = {w, enc, 1'b1};
    @(posedge clk_sys); #1 read_strobe = 0;
    @(posedge clk_sys); #1 {got_v, got_f, got_i} = {result_valid, match_found, match_index};
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  task automatic t_preload;
    srch(32'h0000_0000, 0);
    chk(got_v, 1);
    chk(hits, 32'hffff_ffff);
  endtask
  task automatic t_dup;
    wr(3, 32'h00c0_ffee, 0, 0);
    wr(20, 32'h00c0_ffee, 0, 0);
    srch(32'h00c0_ffee, 0);
    chk(hits, 32'h0010_0008);
  endtask
  task automatic t_enc;
    wr(12, 32'hbeef_0001, 0, 0);
    srch(32'hbeef_0001, 1);
    chk(got_f, 1);
    chk(got_i, 12);
    srch(32'h7777_0000, 1);
    chk(got_f, 0);
  endtask
  task automatic t_mask;
    wr(7, 32'h1234_5600, 32'h0000_00ff, 1);
    srch(32'h1234_565a, 1);
    chk(got_i, 7);
  endtask
  task automatic t_gate;
    @(posedge clk_sys); #1 in_clk_en = 0;
    srch(32'hbeef_0001, 1);
    chk(got_v, 0);
    in_clk_en = 1;
  endtask
  // Search raised together with a write is dropped in single-port setting
  task automatic t_single;
    @(posedge clk_sys); #1 {single_port, write_strobe, write_dc, read_strobe} = 4'b1101;
    @(posedge clk_sys); #1 read_strobe = 0;
    @(posedge clk_sys); #1 write_strobe = 0;
    chk(result_valid, 0);
    @(posedge clk_sys); #1 chk(result_valid, 0);
    single_port = 0;
  endtask
  task automatic t_clear;
    @(posedge clk_sys); #1 clr_local = 1;
    @(posedge clk_sys); #1 clr_local = 0;
    srch(32'hbeef_0001, 1);
    chk(got_f, 0);
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    #1 rst = 0;
    t_preload;
    t_dup;
    t_enc;
    t_mask;
    t_gate;
    t_clear;
    t_single;
    stop_test;
  end
endmodule // emb_cam_tb
`default_nettype wire
